// file: hdl/watchdog_config_register_bank.sv
/*
  Watchdog configuration bank: mask, reset-pin select, soft reset, scratch bytes,
  watchdog settings, saturating error counter and the timeout actions.
  Assumes the serial shifter delivers whole, checked register accesses as one-cycle
  strobes on ref_clk, and the watchdog timer reports errors and good triggers likewise.
  Assumes the flag register drives flagStatus on ref_clk, so it needs no synchroniser;
  only the undervoltage comparator arrives from outside the clock domain.
  Limitation: while the regulator is off the host loses power, so the bank must keep
  counting on its own clock and restore the supply without any host action.
*/
`timescale 1ns/1ps
module watchdog_config_register_bank
  import wd_config_pkg::*;
#(
  parameter int REGULATOR_OFF_COUNT = REGULATOR_OFF_CYCLES,
  parameter int RESET_PULSE_COUNT = RESET_PULSE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire reg_req_t regReq,
  output logic [7:0] regRdata,
  input wire logic [7:0] flagStatus,
  input wire logic regulatorUndervoltage,
  input wire logic watchdogError,
  input wire logic watchdogGoodTrigger,
  output wd_cfg_t watchdogConfig,
  output logic [2:0] prescaleFactor,
  output logic watchdogKick,
  output logic interrupt_out_n,
  output logic regulatorEnable,
  output logic resetPinN
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  // a zero count would leave an action that never shows on its pin
  if (REGULATOR_OFF_COUNT < 1 || RESET_PULSE_COUNT < 1) begin : g_count_low
    $error("timer counts must be at least one cycle");
  end
  // both timers share one width, so their sum must stay inside an int
  if (REGULATOR_OFF_COUNT > 32'h3FFF_FFFF ||
      RESET_PULSE_COUNT > 32'h3FFF_FFFF) begin : g_count_high
    $error("timer counts too large for the shared timer width");
  end

  localparam int TW = $clog2(REGULATOR_OFF_COUNT + RESET_PULSE_COUNT + 1);

  // threshold code to the count that fires the action
  // reserved code 11 falls back to acting on every error, the safest reading
  function automatic logic [3:0] errorLimit(input logic [1:0] code);
    unique case (code)
      THRESH_FIFTH: errorLimit = LIMIT_FIFTH;
      THRESH_NINTH: errorLimit = LIMIT_NINTH;
      default: errorLimit = LIMIT_EVERY;
    endcase
  endfunction

  // a write to a given offset, used by every writable register, soft reset and the kick
  // one shared decode keeps every register aligned on the same offsets
  function automatic logic writeTo(input reg_req_t req, input logic [7:0] a);
    writeTo = req.write && (req.addr == a);
  endfunction

  // ----------------------------------------------------------------------
  // undervoltage comparator synchroniser
  // ----------------------------------------------------------------------
  // uvMeta is read by nothing but uvSync, so a metastable level never fans out
  logic uvMeta;
  logic uvSync;
  logic next_uvMeta;
  logic next_uvSync;

  // the comparator is asynchronous to ref_clk, so two flops before use
  // the extra two cycles of latency are far below any reset timing
  always_comb begin
    next_uvMeta = regulatorUndervoltage;
    next_uvSync = uvMeta;
  end

  // reset to no undervoltage so the reset pin comes out of rst released
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      uvMeta <= 1'b0;
      uvSync <= 1'b0;
    end else begin
      uvMeta <= next_uvMeta;
      uvSync <= next_uvSync;
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  // live register state, and the values they take at the next edge
  logic [7:0] interruptMask;
  logic [7:0] scratchOne;
  logic [7:0] scratchTwo;
  reset_cfg_t resetCfg;
  wd_cfg_t wdCfg;
  logic [7:0] next_interruptMask;
  logic [7:0] next_scratchOne;
  logic [7:0] next_scratchTwo;
  reset_cfg_t next_resetCfg;
  wd_cfg_t next_wdCfg;
  logic softReset;

  // soft reset is decoded from the write itself, so defaults land at the taking edge
  assign softReset = writeTo(regReq, ADDR_RESET_OUTPUT_CONFIG) &&
                     regReq.wdata[SOFT_RESET_BIT]; // R4

  // soft reset takes priority over the data of the same write, so the bit
  // never stores and reads back zero
  // writes to the kick, reserved and count offsets fall through untouched
  always_comb begin
    next_interruptMask = interruptMask;
    next_scratchOne = scratchOne;
    next_scratchTwo = scratchTwo;
    next_resetCfg = resetCfg;
    next_wdCfg = wdCfg;
    if (softReset) begin
      next_interruptMask = MASK_RESET; // R4
      next_scratchOne = SCRATCH_RESET;
      next_scratchTwo = SCRATCH_RESET;
      next_resetCfg.resetOutputSelect = RESET_SEL_UNDERVOLTAGE;
      next_wdCfg = WD_CFG_RESET;
    end else begin
      if (writeTo(regReq, ADDR_INTERRUPT_MASK)) begin
        next_interruptMask = regReq.wdata; // R1
      end
      if (writeTo(regReq, ADDR_SCRATCH_PAD_ONE)) begin
        next_scratchOne = regReq.wdata; // R5
      end
      if (writeTo(regReq, ADDR_SCRATCH_PAD_TWO)) begin
        next_scratchTwo = regReq.wdata; // R5
      end
      if (writeTo(regReq, ADDR_RESET_OUTPUT_CONFIG)) begin
        next_resetCfg.resetOutputSelect = regReq.wdata[RESET_SEL_LSB +: 2]; // R3
      end
      if (writeTo(regReq, ADDR_WATCHDOG_CONFIG)) begin
        next_wdCfg = wd_cfg_t'(regReq.wdata); // R6 R7 R8 R9 R13
      end
    end
  end

  // power-on and soft reset give the same defaults; only their timing differs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      interruptMask <= MASK_RESET; // R1
      scratchOne <= SCRATCH_RESET;
      scratchTwo <= SCRATCH_RESET;
      resetCfg.resetOutputSelect <= RESET_SEL_UNDERVOLTAGE;
      wdCfg <= WD_CFG_RESET;
    end else begin
      interruptMask <= next_interruptMask;
      scratchOne <= next_scratchOne;
      scratchTwo <= next_scratchTwo;
      resetCfg <= next_resetCfg;
      wdCfg <= next_wdCfg;
    end
  end

  // ----------------------------------------------------------------------
  // error counter and action timers
  // ----------------------------------------------------------------------
  // the counter is not touched by soft reset, so a host cannot wipe its own history
  logic [3:0] errorCount;
  logic [3:0] next_errorCount;
  logic wdIntHold;
  logic next_wdIntHold;
  logic [TW-1:0] regOffTimer;
  logic [TW-1:0] next_regOffTimer;
  logic [TW-1:0] pulseTimer;
  logic [TW-1:0] next_pulseTimer;
  logic fireAction;
  logic [3:0] bumped;

  // a disabled watchdog neither counts nor acts
  // an error and a good trigger in one cycle cancel, leaving the count unchanged
  // the count clears once the action fires, so each action needs a fresh run of errors
  always_comb begin
    fireAction = 1'b0;
    bumped = errorCount;
    next_errorCount = errorCount;
    if (!wdCfg.watchdogDisable) begin // R6
      if (watchdogError && !watchdogGoodTrigger) begin
        bumped = (errorCount == ERROR_COUNT_MAX) ? errorCount : errorCount + 4'h1; // R10 R17
        if (bumped >= errorLimit(wdCfg.errorThresholdSelect)) begin
          fireAction = 1'b1; // R12
          next_errorCount = '0;
        end else begin
          next_errorCount = bumped;
        end
      end else if (watchdogGoodTrigger && !watchdogError) begin
        if (errorCount != '0) begin
          next_errorCount = errorCount - 4'h1; // R10 R11
        end
      end
    end
  end

  // action timers; a new trigger restarts a running one
  // soft reset leaves a running action alone; cutting it short could strand the host
  always_comb begin
    next_wdIntHold = wdIntHold;
    next_regOffTimer = regOffTimer;
    next_pulseTimer = pulseTimer;
    if (regOffTimer != '0) begin
      next_regOffTimer = regOffTimer - 1'b1;
    end
    if (pulseTimer != '0) begin
      next_pulseTimer = pulseTimer - 1'b1;
    end
    if (watchdogGoodTrigger) begin
      next_wdIntHold = 1'b0;
    end
    if (fireAction) begin
      unique case (wdCfg.timeoutActionSelect) // R13
        ACTION_INTERRUPT: next_wdIntHold = 1'b1; // set wins over clear
        ACTION_REGULATOR_OFF: next_regOffTimer = TW'(REGULATOR_OFF_COUNT);
        ACTION_RESET_PULSE: next_pulseTimer = TW'(RESET_PULSE_COUNT);
        default: next_wdIntHold = wdIntHold; // R14
      endcase
    end
  end

  // power-on count starts part way up, so early errors act sooner
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      errorCount <= ERROR_COUNT_RESET;
      wdIntHold <= 1'b0;
      regOffTimer <= '0;
      pulseTimer <= '0;
    end else begin
      errorCount <= next_errorCount;
      wdIntHold <= next_wdIntHold;
      regOffTimer <= next_regOffTimer;
      pulseTimer <= next_pulseTimer;
    end
  end

  // ----------------------------------------------------------------------
  // pins, kick and read-back
  // ----------------------------------------------------------------------
  logic next_interrupt_out_n;
  logic next_regulatorEnable;
  logic next_resetPinN;
  logic next_watchdogKick;
  logic [7:0] next_regRdata;
  logic wdPulseActive;

  // the watchdog reset pulse lasts while its timer runs
  assign wdPulseActive = (pulseTimer != '0);

  // all pins are registered so no decode glitch reaches a pin
  // the read data is zero outside a read, so the shifter can merge it freely
  always_comb begin
    next_interrupt_out_n = !(|(flagStatus & ~interruptMask) || wdIntHold); // R2
    next_regulatorEnable = (regOffTimer == '0); // R13
    next_watchdogKick = writeTo(regReq, ADDR_WATCHDOG_KICK); // R16
    unique case (resetCfg.resetOutputSelect) // R3
      RESET_SEL_WATCHDOG: next_resetPinN = !wdPulseActive;
      RESET_SEL_BOTH: next_resetPinN = !(wdPulseActive || uvSync);
      default: next_resetPinN = !uvSync;
    endcase
    next_regRdata = 8'h00; // R15
    if (regReq.read) begin
      unique case (regReq.addr)
        ADDR_INTERRUPT_MASK: next_regRdata = interruptMask;
        ADDR_RESET_OUTPUT_CONFIG: next_regRdata =
            8'(resetCfg.resetOutputSelect) << RESET_SEL_LSB; // R4
        ADDR_SCRATCH_PAD_ONE: next_regRdata = scratchOne;
        ADDR_SCRATCH_PAD_TWO: next_regRdata = scratchTwo;
        ADDR_WATCHDOG_CONFIG: next_regRdata = wdCfg;
        ADDR_ERROR_COUNT: next_regRdata = 8'(errorCount) << ERROR_COUNT_LSB; // R17
        default: next_regRdata = 8'h00; // R15 R16
      endcase
    end
  end

  // pins come out of reset inactive: interrupt high, supply on, reset released
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      interrupt_out_n <= 1'b1;
      regulatorEnable <= 1'b1;
      resetPinN <= 1'b1;
      watchdogKick <= 1'b0;
      regRdata <= 8'h00;
    end else begin
      interrupt_out_n <= next_interrupt_out_n;
      regulatorEnable <= next_regulatorEnable;
      resetPinN <= next_resetPinN;
      watchdogKick <= next_watchdogKick;
      regRdata <= next_regRdata;
    end
  end

  // configuration goes to the watchdog timer straight from the register
  assign watchdogConfig = wdCfg;
  assign prescaleFactor = {1'b0, wdCfg.watchdogPrescale} + 3'h1; // R8

endmodule

// file: hdl/wd_config_pkg.sv
/*
  Constants, field layouts and carrier types for the watchdog configuration bank.
  Assumes one synchronous clock domain shared with the serial shifter and the flag register.
*/
// Operation
// R1 - eight mask bits, one per fault or wake flag, all reset to one
// R2 - a set mask bit keeps its flag off the interrupt output; flag still recorded
// R3 - reset config bits 3:2 choose reset pin role: undervoltage, watchdog or both
// R4 - writing one to soft reset bit restores defaults; bit reads back zero
// R5 - two independent scratch bytes, reset zero, return last written value
// R6 - watchdog config bit 7 disables the whole watchdog when set
// R7 - watchdog config bit 6 selects window (zero) or timeout (one) supervision
// R8 - watchdog config bits 5:4 select prescale factor one to four
// R9 - bits 3:2 set error threshold: every error, fifth error, ninth error
// R10 - error counter counts up on errors, down on correct triggers
// R11 - error counter never goes below zero
// R12 - reaching the threshold performs the selected watchdog action
// R13 - bits 1:0 pick action: interrupt low, regulator off 100 ms, reset pulse
// R14 - host never writes reserved code 11 to select fields
// R15 - reserved bits and registers read zero and ignore writes
// R16 - any write to the kick register restarts the timer; it reads zero
// R17 - error count readable as a read-only four-bit field, up to fifteen
package wd_config_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_INTERRUPT_MASK = 8'h0E;
  localparam logic [7:0] ADDR_RESERVED_BLOCK_A = 8'h0F;
  localparam logic [7:0] ADDR_RESET_OUTPUT_CONFIG = 8'h10;
  localparam logic [7:0] ADDR_SCRATCH_PAD_ONE = 8'h11;
  localparam logic [7:0] ADDR_SCRATCH_PAD_TWO = 8'h12;
  localparam logic [7:0] ADDR_WATCHDOG_CONFIG = 8'h13;
  localparam logic [7:0] ADDR_ERROR_COUNT = 8'h14;
  localparam logic [7:0] ADDR_WATCHDOG_KICK = 8'h15;

  // ----------------------------------------------------------------------
  // reset values and field codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam logic [1:0] RESET_SEL_UNDERVOLTAGE = 2'h0;
  localparam logic [1:0] RESET_SEL_WATCHDOG = 2'h1;
  localparam logic [1:0] RESET_SEL_BOTH = 2'h2;
  localparam logic [1:0] PRESCALE_RESET = 2'h0;
  localparam logic [1:0] THRESH_EVERY = 2'h0;
  localparam logic [1:0] THRESH_FIFTH = 2'h1;
  localparam logic [1:0] THRESH_NINTH = 2'h2;
  localparam logic [1:0] ACTION_INTERRUPT = 2'h0;
  localparam logic [1:0] ACTION_REGULATOR_OFF = 2'h1;
  localparam logic [1:0] ACTION_RESET_PULSE = 2'h2;
  localparam logic [3:0] ERROR_COUNT_RESET = 4'h4;
  localparam logic [3:0] ERROR_COUNT_MAX = 4'hF;
  localparam logic [3:0] LIMIT_EVERY = 4'h1;
  localparam logic [3:0] LIMIT_FIFTH = 4'h5;
  localparam logic [3:0] LIMIT_NINTH = 4'h9;
  localparam int SOFT_RESET_BIT = 0;
  localparam int RESET_SEL_LSB = 2;
  localparam int ERROR_COUNT_LSB = 1;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLOCK_HZ = 125_000_000;
  localparam int REGULATOR_OFF_MS = 100;
  localparam int REGULATOR_OFF_CYCLES = CLOCK_HZ / 1000 * REGULATOR_OFF_MS;
  localparam int RESET_PULSE_CYCLES = 125;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [1:0] resetOutputSelect;
  } reset_cfg_t;

  typedef struct packed {
    logic watchdogDisable;
    logic watchdogTypeSelect;
    logic [1:0] watchdogPrescale;
    logic [1:0] errorThresholdSelect;
    logic [1:0] timeoutActionSelect;
  } wd_cfg_t;

  localparam wd_cfg_t WD_CFG_RESET = '{1'b0, 1'b0, PRESCALE_RESET, THRESH_EVERY,
                                       ACTION_RESET_PULSE};

endpackage

// file: verification/host_model.sv
/*
  Host model: single-byte register writes and reads, one strobe cycle each.
  Assumes the bank takes a strobe at a rising edge and answers one cycle on.
*/
`timescale 1ns/1ps
module host_model
  import wd_config_pkg::*;
(
  input logic ref_clk,
  input logic [7:0] regRdata,
  output reg_req_t regReq
);
  initial regReq = '0;
  // strobe held through exactly one edge; callers keep select fields off code 11
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 regReq = '{1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    #1 regReq = '0;
  endtask
  // read data is registered, so it is valid just after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1 regReq = '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk);
    #1 regReq = '0;
    d = regRdata;
  endtask
endmodule

// file: verification/tb_watchdog_config_register_bank.sv
/*
  Self-checking bench for the watchdog configuration bank.
  Assumes the host model drives the register strobes; counts shortened by parameter.
*/
`timescale 1ns/1ps
module tb_watchdog_config_register_bank
  import wd_config_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and checking
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  reg_req_t regReq;
  logic [7:0] regRdata, rdVal, flagStatus = 8'h00;
  logic uv = 1'b0, err = 1'b0, good = 1'b0, kick, intN, regEn, rstN;
  wd_cfg_t cfg;
  logic [2:0] pf;
  int n_errors = 0, samples_checked = 0;
  always #4 ref_clk = ~ref_clk;
  watchdog_config_register_bank #(.REGULATOR_OFF_COUNT(20), .RESET_PULSE_COUNT(5)) dut (
    .ref_clk(ref_clk), .rst(rst), .regReq(regReq), .regRdata(regRdata),
    .flagStatus(flagStatus), .regulatorUndervoltage(uv), .watchdogError(err),
    .watchdogGoodTrigger(good), .watchdogConfig(cfg), .prescaleFactor(pf),
    .watchdogKick(kick), .interrupt_out_n(intN), .regulatorEnable(regEn),
    .resetPinN(rstN));
  host_model u_host (.ref_clk(ref_clk), .regRdata(regRdata), .regReq(regReq));
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, rdVal);
    check($sformatf("reg %h", a), rdVal, exp);
  endtask
  // one-cycle error (e=1) or good trigger (e=0) pulses, a gap between each
  task automatic pulse(input logic e, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1 err = e;
      good = !e;
      @(posedge ref_clk);
      #1 err = 1'b0;
      good = 1'b0;
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic t_defaults;
    logic [7:0] adr[8] = '{8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
    logic [7:0] exv[8] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h08, 8'h00};
    for (int i = 0; i < 8; i++) rdChk(adr[i], exv[i]);
    $display("defaults done");
  endtask
  task automatic t_access;
    u_host.wr(8'h11, 8'hA5);
    u_host.wr(8'h12, 8'h5A);
    rdChk(8'h11, 8'hA5);
    rdChk(8'h12, 8'h5A);
    u_host.wr(8'h0F, 8'hFF);
    rdChk(8'h0F, 8'h00);
    u_host.wr(8'h10, 8'hFA);
    rdChk(8'h10, 8'h08);
    u_host.wr(8'h14, 8'hFF);
    rdChk(8'h14, 8'h08);
    for (int p = 0; p < 4; p++) begin
      u_host.wr(8'h13, 8'h82 | 8'(p << 4));
      check("prescale", {5'h00, pf}, 8'(p + 1));
    end
    u_host.wr(8'h13, 8'hC6);
    rdChk(8'h13, 8'hC6);
    check("config out", cfg, 8'hC6);
    $display("access done");
  endtask
  task automatic t_mask_soft;
    flagStatus = 8'h01;
    waitc(3);
    check("int masked", intN, 8'h01);
    u_host.wr(8'h0E, 8'hFE);
    waitc(2);
    check("int open", intN, 8'h00);
    flagStatus = 8'h00;
    u_host.wr(8'h10, 8'h05);
    rdChk(8'h0E, 8'hFF);
    rdChk(8'h10, 8'h00);
    rdChk(8'h11, 8'h00);
    rdChk(8'h13, 8'h02);
    u_host.wr(8'h15, 8'h33);
    check("kick", kick, 8'h01);
    waitc(1);
    check("kick over", kick, 8'h00);
    $display("mask and soft reset done");
  endtask
  task automatic t_select;
    uv = 1'b1;
    waitc(5);
    check("uv reset", rstN, 8'h00);
    uv = 1'b0;
    waitc(5);
    u_host.wr(8'h10, 8'h08);
    uv = 1'b1;
    waitc(5);
    check("uv both", rstN, 8'h00);
    uv = 1'b0;
    waitc(5);
    check("uv released", rstN, 8'h01);
    u_host.wr(8'h10, 8'h04);
    uv = 1'b1;
    waitc(5);
    check("uv ignored", rstN, 8'h01);
    uv = 1'b0;
    $display("select done");
  endtask
  // error counter walk and every defined action code; reset pin now watchdog-only
  task automatic t_counter;
    u_host.wr(8'h13, 8'h16);
    pulse(1'b0, 5);
    rdChk(8'h14, 8'h00);
    pulse(1'b1, 4);
    rdChk(8'h14, 8'h08);
    pulse(1'b1, 1);
    waitc(1);
    check("reset pulse", rstN, 8'h00);
    rdChk(8'h14, 8'h00);
    u_host.wr(8'h13, 8'h01);
    pulse(1'b1, 1);
    waitc(3);
    check("regulator off", regEn, 8'h00);
    waitc(25);
    check("regulator back", regEn, 8'h01);
    u_host.wr(8'h13, 8'h00);
    pulse(1'b1, 1);
    waitc(3);
    check("int action", intN, 8'h00);
    pulse(1'b0, 1);
    waitc(3);
    check("int cleared", intN, 8'h01);
    u_host.wr(8'h13, 8'h84);
    pulse(1'b1, 3);
    rdChk(8'h14, 8'h00);
    u_host.wr(8'h13, 8'h09);
    pulse(1'b1, 8);
    rdChk(8'h14, 8'h10);
    pulse(1'b1, 1);
    waitc(2);
    check("ninth error", regEn, 8'h00);
    waitc(25);
    $display("counter done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // main sequence: reset held two cycles, then each scenario in turn
  initial begin
    waitc(2);
    rst = 1'b0;
    t_defaults();
    t_access();
    t_mask_soft();
    t_select();
    t_counter();
    summarize();
  end
  // run needs well under 1000 cycles; cut a hang short
  initial begin
    #40000;
    n_errors++;
    summarize();
  end
endmodule

// file: verification/wd_bank_checker.sv
/*
  Port assertions for the watchdog configuration bank.
  Assumes one clock, ref_clk, and a synchronous active-high rst.
*/
`timescale 1ns/1ps
module wd_bank_checker
  import wd_config_pkg::*;
#(
  parameter int REGULATOR_OFF_COUNT = 20,
  parameter int RESET_PULSE_COUNT = 5
) (
  input logic ref_clk,
  input logic rst,
  input reg_req_t regReq,
  input logic [7:0] regRdata,
  input logic [7:0] flagStatus,
  input logic regulatorUndervoltage,
  input logic watchdogError,
  input logic watchdogGoodTrigger,
  input wd_cfg_t watchdogConfig,
  input logic [2:0] prescaleFactor,
  input logic watchdogKick,
  input logic interrupt_out_n,
  input logic regulatorEnable,
  input logic resetPinN
);
  // ----------------------------------------------------------------
  // relations at the ports
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_kick_pulse: assert property (
    regReq.write && regReq.addr == ADDR_WATCHDOG_KICK |=> watchdogKick ##1 !watchdogKick)
    else $error("kick pulse wrong");
  a_idle_rdata: assert property (
    !regReq.read |=> regRdata == 8'h00) else $error("read data not zero when idle");
  a_rsvd_read: assert property (
    regReq.read && regReq.addr == ADDR_RESERVED_BLOCK_A |=> regRdata == 8'h00)
    else $error("reserved byte not zero");
  a_prescale_map: assert property (
    prescaleFactor == {1'b0, watchdogConfig.watchdogPrescale} + 3'h1)
    else $error("prescale factor wrong");
  a_soft_reset: assert property (
    regReq.write && regReq.addr == ADDR_RESET_OUTPUT_CONFIG && regReq.wdata[0]
    |=> watchdogConfig == WD_CFG_RESET) else $error("soft reset missed config");
  a_cfg_store: assert property (
    regReq.write && regReq.addr == ADDR_WATCHDOG_CONFIG
    |=> watchdogConfig == $past(regReq.wdata)) else $error("config not stored");
  a_regoff_cause: assert property (
    $fell(regulatorEnable) |-> $past(watchdogError, 2)
    && watchdogConfig.timeoutActionSelect == ACTION_REGULATOR_OFF)
    else $error("regulator off without cause");
  // uv is held low by the bench around every watchdog reset pulse
  a_reset_pulse: assert property (
    $fell(resetPinN) && $past(watchdogError, 2) |-> !resetPinN [*5] ##1 resetPinN)
    else $error("reset pulse length wrong");
  a_disabled_quiet: assert property (
    watchdogError && watchdogConfig.watchdogDisable && regulatorEnable && resetPinN
    |=> ##1 regulatorEnable && resetPinN) else $error("disabled watchdog acted");
  c_kick: cover property (watchdogKick);
  c_regoff: cover property ($fell(regulatorEnable));
  c_rstpin: cover property ($fell(resetPinN));
  c_int: cover property ($fell(interrupt_out_n));
endmodule

bind watchdog_config_register_bank wd_bank_checker #(
  .REGULATOR_OFF_COUNT(REGULATOR_OFF_COUNT), .RESET_PULSE_COUNT(RESET_PULSE_COUNT)
) u_chk (
  .ref_clk(ref_clk), .rst(rst), .regReq(regReq), .regRdata(regRdata),
  .flagStatus(flagStatus), .regulatorUndervoltage(regulatorUndervoltage),
  .watchdogError(watchdogError), .watchdogGoodTrigger(watchdogGoodTrigger),
  .watchdogConfig(watchdogConfig), .prescaleFactor(prescaleFactor),
  .watchdogKick(watchdogKick), .interrupt_out_n(interrupt_out_n),
  .regulatorEnable(regulatorEnable), .resetPinN(resetPinN)
);
